// [hw/dus_pkg.sv]
/*
  constants for the two-channel dac update scheduler: register addresses,
  control field positions, reset values, update modes and format codes.
  assumes an 8-bit special-function-register bus with 8-bit addresses.
*/
// Behaviour
// - mode 00: high byte write loads latch
// - modes 01/10/11: latch on timer 3/4/2 overflow
// - low byte write alone never changes latch
// - latch holds one 12-bit code per channel
// - format 000: high[3:0] then full low byte
// - five-bit high, seven-bit low layout
// - format 010: high[5:0] then low[7:2]
// - seven-bit high, five-bit low layout
// - format 1xx: high[7:0] then low[7:4]
// - control bit 7 enables channel output
// - bits 4:3 mode, bits 2:0 format, read/write
// - control bits 6:5 read zero, ignore writes
// - separate 8-bit high and low data registers
// - second channel behaves identically, own registers
// - timer overflow itself triggers transfer, no jitter
package dus_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [7:0] DUS_ADDR_CH0_LOW  = 8'hd2;
  localparam logic [7:0] DUS_ADDR_CH0_HIGH = 8'hd3;
  localparam logic [7:0] DUS_ADDR_CH0_CTRL = 8'hd4;
  localparam logic [7:0] DUS_ADDR_CH1_LOW  = 8'hd5;
  localparam logic [7:0] DUS_ADDR_CH1_HIGH = 8'hd6;
  localparam logic [7:0] DUS_ADDR_CH1_CTRL = 8'hd7;

  // ****************************************************************
  // control fields and reset values
  // ****************************************************************
  localparam int         DUS_EN_BIT      = 7;
  localparam int         DUS_MODE_MSB    = 4;
  localparam int         DUS_MODE_LSB    = 3;
  localparam int         DUS_FMT_MSB     = 2;
  localparam int         DUS_FMT_LSB     = 0;
  localparam logic [7:0] DUS_CTRL_MASK   = 8'h9f;
  localparam logic [7:0] DUS_REG_RESET   = 8'h00;
  localparam logic [11:0] DUS_CODE_RESET = 12'h000;

  // ****************************************************************
  // update modes and format codes
  // ****************************************************************
  localparam logic [1:0] DUS_MODE_ON_WRITE = 2'h0;
  localparam logic [1:0] DUS_MODE_TIMER3   = 2'h1;
  localparam logic [1:0] DUS_MODE_TIMER4   = 2'h2;
  localparam logic [1:0] DUS_MODE_TIMER2   = 2'h3;
  localparam logic [2:0] DUS_FMT_4_8       = 3'h0;
  localparam logic [2:0] DUS_FMT_5_7       = 3'h1;
  localparam logic [2:0] DUS_FMT_6_6       = 3'h2;
  localparam logic [2:0] DUS_FMT_7_5       = 3'h3;

endpackage : dus_pkg

// [hw/dus_channel.sv]
/*
  one dac channel: control and data byte registers, code assembly and the
  12-bit input latch. assumes write strobes are one-cycle pulses and timer
  overflow inputs are synchronous one-cycle pulses.
*/
`timescale 1ns/10ps
module dus_channel
  import dus_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic        wr_ctrl,
  input  wire logic [7:0]  wr_data,
  input  wire logic        timer2_ovf,
  input  wire logic        timer3_ovf,
  input  wire logic        timer4_ovf,
  output logic      [7:0]  data_low,
  output logic      [7:0]  data_high,
  output logic      [7:0]  control,
  output logic      [11:0] code,
  output logic             enable
);

  // ****************************************************************
  // justification
  // ****************************************************************
  // maps high:low bytes to the 12-bit code for a format code
  function automatic logic [11:0] dus_assemble(input logic [2:0] fmt,
                                               input logic [7:0] hi,
                                               input logic [7:0] lo);
    logic [11:0] r;
    r = DUS_CODE_RESET;
    if (fmt[2]) begin
      r = {hi[7:0], lo[7:4]};
    end else begin
      unique case (fmt[1:0])
        DUS_FMT_4_8[1:0]: r = {hi[3:0], lo[7:0]};
        DUS_FMT_5_7[1:0]: r = {hi[4:0], lo[7:1]};
        DUS_FMT_6_6[1:0]: r = {hi[5:0], lo[7:2]};
        DUS_FMT_7_5[1:0]: r = {hi[6:0], lo[7:3]};
      endcase
    end
    return r;
  endfunction : dus_assemble

  logic [7:0]  low_q, low_d;
  logic [7:0]  high_q, high_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [11:0] code_q, code_d;
  logic [1:0]  mode;
  logic        fire;

  assign mode = ctrl_q[DUS_MODE_MSB:DUS_MODE_LSB];

  // ****************************************************************
  // registers and latch transfer
  // ****************************************************************
  // the latch loads from the byte values as they stand after this edge,
  // so a high-byte write and its transfer land together
  always_comb begin
    low_d  = low_q;
    high_d = high_q;
    ctrl_d = ctrl_q;
    if (wr_low) begin
      low_d = wr_data;
    end
    if (wr_high) begin
      high_d = wr_data;
    end
    if (wr_ctrl) begin
      ctrl_d = wr_data & DUS_CTRL_MASK;
    end
    // in timer modes the overflow pulse alone decides the moment, not bus traffic; mode 00 fires on the high-byte write
    fire = 1'b0;
    unique case (mode)
      DUS_MODE_ON_WRITE: fire = wr_high;
      DUS_MODE_TIMER3:   fire = timer3_ovf;
      DUS_MODE_TIMER4:   fire = timer4_ovf;
      DUS_MODE_TIMER2:   fire = timer2_ovf;
    endcase
    code_d = code_q;
    if (fire) begin
      code_d = dus_assemble(ctrl_q[DUS_FMT_MSB:DUS_FMT_LSB],
                            high_d, low_d);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      low_q  <= DUS_REG_RESET;
      high_q <= DUS_REG_RESET;
      ctrl_q <= DUS_REG_RESET;
      code_q <= DUS_CODE_RESET;
    end else begin
      low_q  <= low_d;
      high_q <= high_d;
      ctrl_q <= ctrl_d;
      code_q <= code_d;
    end
  end

  assign data_low  = low_q;
  assign data_high = high_q;
  assign control   = ctrl_q;
  assign code      = code_q;
  assign enable    = ctrl_q[DUS_EN_BIT];

endmodule : dus_channel

// [hw/dus_top.sv]
/*
  two-channel dac update scheduler on the special-function-register bus.
  assumes single-cycle sfr writes and reads with a registered read answer,
  and timer overflow strobes that are one-cycle pulses on core_clk.
*/
`timescale 1ns/10ps
module dus_top
  import dus_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic        timer2_ovf,
  input  wire logic        timer3_ovf,
  input  wire logic        timer4_ovf,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  output logic      [11:0] ch0_code,
  output logic             ch0_enable,
  output logic      [11:0] ch1_code,
  output logic             ch1_enable
);

  logic [7:0]  lo0, hi0, cn0, lo1, hi1, cn1;
  logic [7:0]  rdata_q, rdata_d;
  logic        hit_q, hit_d;
  logic        sel;

  // ****************************************************************
  // channels
  // ****************************************************************
  // second channel is the same module with its own addresses
  dus_channel u_ch0 (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .wr_low     (sfr_wr && sfr_addr == DUS_ADDR_CH0_LOW),
    .wr_high    (sfr_wr && sfr_addr == DUS_ADDR_CH0_HIGH),
    .wr_ctrl    (sfr_wr && sfr_addr == DUS_ADDR_CH0_CTRL),
    .wr_data    (sfr_wdata),
    .timer2_ovf (timer2_ovf),
    .timer3_ovf (timer3_ovf),
    .timer4_ovf (timer4_ovf),
    .data_low   (lo0),
    .data_high  (hi0),
    .control    (cn0),
    .code       (ch0_code),
    .enable     (ch0_enable)
  );

  dus_channel u_ch1 (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .wr_low     (sfr_wr && sfr_addr == DUS_ADDR_CH1_LOW),
    .wr_high    (sfr_wr && sfr_addr == DUS_ADDR_CH1_HIGH),
    .wr_ctrl    (sfr_wr && sfr_addr == DUS_ADDR_CH1_CTRL),
    .wr_data    (sfr_wdata),
    .timer2_ovf (timer2_ovf),
    .timer3_ovf (timer3_ovf),
    .timer4_ovf (timer4_ovf),
    .data_low   (lo1),
    .data_high  (hi1),
    .control    (cn1),
    .code       (ch1_code),
    .enable     (ch1_enable)
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  // read data holds its last value between reads; unmapped reads give 0
  always_comb begin
    rdata_d = rdata_q;
    sel     = 1'b1;
    unique case (sfr_addr)
      DUS_ADDR_CH0_LOW:  rdata_d = lo0;
      DUS_ADDR_CH0_HIGH: rdata_d = hi0;
      DUS_ADDR_CH0_CTRL: rdata_d = cn0;
      DUS_ADDR_CH1_LOW:  rdata_d = lo1;
      DUS_ADDR_CH1_HIGH: rdata_d = hi1;
      DUS_ADDR_CH1_CTRL: rdata_d = cn1;
      default: begin
        rdata_d = DUS_REG_RESET;
        sel     = 1'b0;
      end
    endcase
    if (!sfr_rd) begin
      rdata_d = rdata_q;
    end
    hit_d = sfr_rd && sel;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= DUS_REG_RESET;
      hit_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_hit   = hit_q;

endmodule : dus_top

// [verification/dus_top_monitor.sv]
/* checker on dus_top ports: latch causes, enables and read answers.
   assumes a bind onto dus_top. */
`timescale 1ns/10ps
module dus_top_monitor
  import dus_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic        timer2_ovf,
  input wire logic        timer3_ovf,
  input wire logic        timer4_ovf,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic [11:0] ch0_code,
  input wire logic        ch0_enable,
  input wire logic [11:0] ch1_code,
  input wire logic        ch1_enable
);
  // ****************************************************************
  // port relations
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic ovf = timer2_ovf | timer3_ovf | timer4_ovf;
  // the past reset term keeps a mid-run reset from looking like a load
  ch0_latch_cause_a: assert property ($changed(ch0_code) && $past(rst_n) |->
    $past(ovf || (sfr_wr && sfr_addr == DUS_ADDR_CH0_HIGH)))
    else $error("ch0 code moved without cause");
  ch1_latch_cause_a: assert property ($changed(ch1_code) && $past(rst_n) |->
    $past(ovf || (sfr_wr && sfr_addr == DUS_ADDR_CH1_HIGH)))
    else $error("ch1 code moved without cause");
  low_write_hold_a: assert property (sfr_wr && !ovf &&
    sfr_addr == DUS_ADDR_CH0_LOW |=> $stable(ch0_code))
    else $error("low write moved code");
  ch0_enable_wr_a: assert property (sfr_wr && sfr_addr == DUS_ADDR_CH0_CTRL
    |=> ch0_enable == $past(sfr_wdata[7]))
    else $error("ch0 enable wrong");
  ch1_enable_wr_a: assert property (sfr_wr && sfr_addr == DUS_ADDR_CH1_CTRL
    |=> ch1_enable == $past(sfr_wdata[7]))
    else $error("ch1 enable wrong");
  hit_map_a: assert property (sfr_rd |=>
    sfr_hit == ($past(sfr_addr) inside {[8'hd2:8'hd7]}))
    else $error("hit wrong");
  ctrl_pad_zero_a: assert property (sfr_rd && (sfr_addr == DUS_ADDR_CH0_CTRL
    || sfr_addr == DUS_ADDR_CH1_CTRL) |=> sfr_rdata[6:5] == 2'h0)
    else $error("unused bits read set");
  hit_one_cycle_a: assert property (sfr_hit |-> $past(sfr_rd))
    else $error("hit without read");
  high_load_c: cover property (sfr_wr && sfr_addr == DUS_ADDR_CH0_HIGH);
  timer_load_c: cover property (timer2_ovf ##1 $changed(ch1_code));
  unmapped_c: cover property (sfr_rd && sfr_addr == 8'hd0);
endmodule : dus_top_monitor

bind dus_top dus_top_monitor dus_top_monitor_inst (.*);

// [verification/dus_timer_model.sv]
/* timer overflow source: one-cycle strobes on request.
   assumes callers issue one request at a time. */
`timescale 1ns/10ps
module dus_timer_model (
  input  wire logic core_clk,
  output logic      timer2_ovf,
  output logic      timer3_ovf,
  output logic      timer4_ovf
);
  // ****************************************************************
  // strobe generation
  // ****************************************************************
  initial {timer2_ovf, timer3_ovf, timer4_ovf} = 3'h0;
  // strobes come from the clock, not the bus, so updates carry no jitter
  task automatic fire(input int t);
    @(posedge core_clk);
    {timer4_ovf, timer3_ovf, timer2_ovf} <= 3'(1 << (t - 2));
    @(posedge core_clk);
    {timer4_ovf, timer3_ovf, timer2_ovf} <= 3'h0;
  endtask : fire
endmodule : dus_timer_model

// [verification/tb_dus_top.sv]
/* self-checking bench for dus_top: register map, formats, update modes.
   assumes the timer model as overflow source. */
`timescale 1ns/10ps
module tb_dus_top
  import dus_pkg::*;
;
  // ****************************************************************
  // stimulus and reference model
  // ****************************************************************
  logic core_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_hit, timer2_ovf, timer3_ovf, timer4_ovf;
  logic [11:0] cw[2], ch0_code, ch1_code;
  logic ew[2], ch0_enable, ch1_enable;
  int fails = 0, checked = 0, lo[2], hi[2], ct[2], cd[2], c, f, m;
  int tm[4] = '{0, 3, 4, 2};
  always #20 core_clk = ~core_clk;
  dus_timer_model dus_timer_model_inst (.core_clk(core_clk),
    .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf), .timer4_ovf(timer4_ovf));
  dus_top dus_top_inst (.core_clk(core_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf),
    .timer4_ovf(timer4_ovf), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .ch0_code(ch0_code), .ch0_enable(ch0_enable), .ch1_code(ch1_code),
    .ch1_enable(ch1_enable));
  // per-channel views so the scenarios can index a channel by number
  always_comb begin
    cw[0] = ch0_code;
    cw[1] = ch1_code;
    ew[0] = ch0_enable;
    ew[1] = ch1_enable;
  end
  // code assembly from the bytes and format held in the model
  function automatic int fmtc(input int b);
    case (ct[b] & 7)
      0: return ((hi[b] & 15) << 8) | lo[b];
      1: return ((hi[b] & 31) << 7) | (lo[b] >> 1);
      2: return ((hi[b] & 63) << 6) | (lo[b] >> 2);
      3: return ((hi[b] & 127) << 5) | (lo[b] >> 3);
      default: return (hi[b] << 4) | (lo[b] >> 4);
    endcase
  endfunction : fmtc
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input int e, input logic [11:0] g);
    checked++;
    if (g !== 12'(e)) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_code(input string n, input int b);
    chk(n, cd[b], cw[b]);
  endtask : chk_code
  task automatic chk_en(input int b);
    chk("enable", ct[b] >> 7, {11'h0, ew[b]});
  endtask : chk_en
  // bus write: held one cycle, model updated when the write is taken
  task automatic wr(input int a, input int d);
    int b;
    b = (a >= 'hd5);
    @(posedge core_clk);
    {sfr_addr, sfr_wdata, sfr_wr} <= {8'(a), 8'(d), 1'b1};
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    #1;
    case (a - (b ? 'hd5 : 'hd2))
      0: lo[b] = d;
      1: begin
        hi[b] = d;
        if (((ct[b] >> 3) & 3) == 0) cd[b] = fmtc(b);
      end
      default: ct[b] = d & 'h9f;
    endcase
  endtask : wr
  task automatic rd(input int a, input int e, input int h);
    @(posedge core_clk);
    {sfr_addr, sfr_rd} <= {8'(a), 1'b1};
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk("read data", e, {4'h0, sfr_rdata});
    chk("read hit", h, {11'h0, sfr_hit});
  endtask : rd
  task automatic fire(input int t);
    dus_timer_model_inst.fire(t);
    #1;
    for (int b = 0; b < 2; b++) begin
      if (tm[(ct[b] >> 3) & 3] == t) cd[b] = fmtc(b);
    end
  endtask : fire
  initial begin
    #100000;
    fails++;
    test_done;
  end
  initial begin
    void'($urandom(44588));
    lo = '{0, 0}; hi = '{0, 0}; ct = '{0, 0}; cd = '{0, 0};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 'hd0; a < 'hd9; a++) rd(a, 0, a inside {['hd2:'hd7]});
    // every format on both channels; unused control bits always written 1
    for (c = 0; c < 2; c++) for (f = 0; f < 8; f++) begin
      wr('hd4 + 3 * c, ($urandom & 'h80) | 'h60 | f);
      rd('hd4 + 3 * c, ct[c], 1);
      chk_en(c);
      wr('hd2 + 3 * c, $urandom & 'hff);
      chk_code("low only", c);
      wr('hd3 + 3 * c, $urandom & 'hff);
      chk_code("code", c);
      // reading the byte back must not disturb the latch
      rd('hd3 + 3 * c, hi[c], 1);
      chk_code("code", c);
      chk_code("other code", 1 - c);
    end
    // each timer mode: only its own overflow loads the latch
    for (m = 1; m < 4; m++) begin
      c = m & 1;
      wr('hd4 + 3 * c, (m << 3) | 4);
      wr('hd2 + 3 * c, 0);
      wr('hd3 + 3 * c, $urandom & 'hff);
      chk_code("held", c);
      for (int t = 2; t < 5; t++) begin
        fire(t);
        chk_code("timer load", c);
      end
    end
    test_done;
  end
endmodule : tb_dus_top
